// file: verif/mdc_ctrl_model.sv
// motion controller model: step, direction and enable levels
// assumes the drive samples its inputs on rising sys_clk edges
`timescale 1ns/1ps
module mdc_ctrl_model (
   input wire logic sys_clk,
   output logic step_pulse_in,
   output logic step_dir_in,
   output logic drive_allow_in
);
   // idle levels: no step, direction up, drive held off
   initial begin
      step_pulse_in = 1'b0;
      step_dir_in = 1'b1;
      drive_allow_in = 1'b0;
   end

   // enable level only moves just after a clock edge
   task automatic set_allow(input logic en);
      @(posedge sys_clk);
      drive_allow_in <= en;
   endtask

   // one pulse per microstep; 3 cycles high, 3 low, above the 2-cycle minimum
   task automatic steps(input int n, input logic up);
      @(posedge sys_clk);
      step_dir_in <= up;
      // direction settles well before the first rise
      repeat (2) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         step_pulse_in <= 1'b1;
         repeat (3) @(posedge sys_clk);
         step_pulse_in <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
   endtask
endmodule

// file: verif/microstep_drive_control_tb.sv
// self-checking bench for the drive control block
// assumes mdc_ctrl_model as far side and a short standstill count
`timescale 1ns/1ps
module microstep_drive_control_tb;
   import mdc_pkg::*;
   logic sys_clk, reset_n, clk_en, fault_detect_in, reg_wr, reg_rd;
   logic [2:0] cur_code, res_code;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
   logic irq, led_green, led_red, winding_enable, standstill;
   logic step_pulse_in, step_dir_in, drive_allow_in;
   logic [7:0] phase_pos;
   logic [10:0] current_ma;
   logic [15:0] microsteps_per_rev;
   int errors, tests_run;

   // short idle count keeps the run brief
   mdc_top #(.STANDSTILL_CYCLES_P(50)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
      .clk_en(clk_en), .step_pulse_in(step_pulse_in), .step_dir_in(step_dir_in),
      .drive_allow_in(drive_allow_in), .fault_detect_in(fault_detect_in),
      .current_sel_bit0(cur_code[0]), .current_sel_bit1(cur_code[1]),
      .current_sel_bit2(cur_code[2]), .resolution_sel_bit0(res_code[0]),
      .resolution_sel_bit1(res_code[1]), .resolution_sel_bit2(res_code[2]),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .led_green(led_green), .led_red(led_red),
      .winding_enable(winding_enable), .phase_pos(phase_pos), .current_ma(current_ma),
      .microsteps_per_rev(microsteps_per_rev), .standstill(standstill));

   mdc_ctrl_model ctrl_u (.sys_clk(sys_clk), .step_pulse_in(step_pulse_in),
      .step_dir_in(step_dir_in), .drive_allow_in(drive_allow_in));

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // expected peak current in mA; all-on pattern falls back to the lowest
   function automatic logic [10:0] cur_exp(input logic [2:0] c);
      if (c == 3'h0) return 11'h0d2;
      if (c == 3'h7) return 11'h5dc;
      return 11'(c) * 11'h0d2;
   endfunction

   // expected steps per revolution, doubling per code up to code 6; code 7 repeats code 6
   function automatic logic [15:0] res_exp(input logic [2:0] c);
      if (c == 3'h7) return 16'h3200;
      return 16'h00c8 << c;
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // samples land 1 ns after the edge, clear of input updates
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // bounded wait; a hang ends the run as a mismatch
   task automatic wait_still(input int lim);
      int n;
      n = 0;
      while (standstill !== 1'b1 && n < lim) begin
         wait_cyc(1);
         n++;
      end
      if (n >= lim) begin
         errors++;
         $display("mismatch standstill expected 1 seen 0");
         report_and_stop();
      end
   endtask

   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      fault_detect_in = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      cur_code = 3'h0;
      res_code = 3'h0;
      errors = 0;
      tests_run = 0;
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      wait_cyc(2);
      check("led_green", led_green, 1'b1);
      check("led_red", led_red, 1'b0);
      reg_read(OFS_IRQ_MASK, rd_val);
      check("irq mask reset", rd_val, 32'h0);
      reg_read(8'h20, rd_val);
      check("unmapped read", rd_val, 32'h0);
      $display("test reset done");
      // reduction off so every code shows its full level
      reg_write(OFS_CTRL, 32'h0);
      ctrl_u.set_allow(1'b1);
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         cur_code <= 3'(i);
         res_code <= 3'(7 - i);
         wait_cyc(3);
         check("current_ma", current_ma, cur_exp(3'(i)));
         check("steps_per_rev", microsteps_per_rev, res_exp(3'(7 - i)));
      end
      $display("test decode done");
      // resolution only changed at rest, current picked to suit the motor
      @(posedge sys_clk);
      cur_code <= 3'h7;
      res_code <= 3'h0;
      ctrl_u.steps(3, 1'b1);
      wait_cyc(4);
      check("pos up", phase_pos, 8'hc0);
      ctrl_u.steps(2, 1'b0);
      wait_cyc(4);
      check("pos down", phase_pos, 8'h40);
      @(posedge sys_clk);
      res_code <= 3'h6;
      ctrl_u.steps(1, 1'b1);
      wait_cyc(4);
      check("pos finest", phase_pos, 8'h41);
      ctrl_u.set_allow(1'b0);
      wait_cyc(3);
      check("winding off", winding_enable, 1'b0);
      check("current off", current_ma, 11'h0);
      ctrl_u.steps(1, 1'b1);
      wait_cyc(4);
      check("pos held", phase_pos, 8'h41);
      $display("test steps done");
      ctrl_u.set_allow(1'b1);
      reg_write(OFS_CTRL, 32'h1);
      // drop events left over from the decode phase
      reg_write(OFS_IRQ_STAT, 32'h7);
      reg_write(OFS_IRQ_MASK, 32'h2);
      ctrl_u.steps(1, 1'b1);
      wait_cyc(40);
      check("no early standstill", standstill, 1'b0);
      check("irq quiet", irq, 1'b0);
      wait_still(40);
      wait_cyc(2);
      check("reduced", current_ma, 11'(32'(cur_exp(3'h7)) * 32'h3c / 32'h64));
      check("irq raised", irq, 1'b1);
      reg_write(OFS_IRQ_STAT, 32'h2);
      wait_cyc(1);
      check("irq cleared", irq, 1'b0);
      ctrl_u.steps(1, 1'b1);
      wait_cyc(2);
      check("standstill left", standstill, 1'b0);
      check("full again", current_ma, cur_exp(3'h7));
      reg_read(OFS_POSITION, rd_val);
      check("position reg", rd_val, 32'h05dc0043);
      $display("test standstill done");
      // a low clock enable freezes the synchroniser, so a whole pulse is lost
      @(posedge sys_clk);
      clk_en <= 1'b0;
      ctrl_u.steps(1, 1'b1);
      wait_cyc(4);
      check("frozen pos", phase_pos, 8'h43);
      check("frozen current", current_ma, cur_exp(3'h7));
      @(posedge sys_clk);
      clk_en <= 1'b1;
      wait_cyc(2);
      check("thawed pos", phase_pos, 8'h43);
      $display("test clock enable done");
      @(posedge sys_clk);
      fault_detect_in <= 1'b1;
      @(posedge sys_clk);
      fault_detect_in <= 1'b0;
      wait_cyc(3);
      check("red on", led_red, 1'b1);
      check("shaft free", winding_enable, 1'b0);
      reg_write(OFS_IRQ_STAT, 32'h7);
      reg_write(OFS_CTRL, 32'h0);
      ctrl_u.set_allow(1'b0);
      ctrl_u.set_allow(1'b1);
      wait_cyc(20);
      check("fault held", led_red, 1'b1);
      check("still free", winding_enable, 1'b0);
      // only a reset clears the fault
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      wait_cyc(3);
      check("red after reset", led_red, 1'b0);
      check("green after reset", led_green, 1'b1);
      reg_read(OFS_STATUS, rd_val);
      check("status after reset", rd_val, 32'h00006704);
      // software force latches the fault as well
      reg_write(OFS_CTRL, 32'h2);
      wait_cyc(2);
      check("forced fault", led_red, 1'b1);
      $display("test fault done");
      report_and_stop();
   end
endmodule

// file: verilog/mdc_pkg.sv
// constants for the microstep drive control block
// assumes a single 100 MHz system clock and a word-wide register port
package mdc_pkg;
   // system clock and standstill timing
   localparam int unsigned CLK_FREQ_HZ = 100000000;
   localparam int unsigned STANDSTILL_MS = 400;
   localparam int unsigned STANDSTILL_CYCLES = (CLK_FREQ_HZ / 1000) * STANDSTILL_MS;
   localparam logic [6:0] REDUCE_PCT = 7'h3c;

   // register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_POSITION = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

   // control fields
   localparam int CTRL_REDUCE_BIT = 0;
   localparam int CTRL_FORCE_FAULT_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;

   // status fields
   localparam int ST_FAULT_BIT = 0;
   localparam int ST_STANDSTILL_BIT = 1;
   localparam int ST_ENERGISED_BIT = 2;
   localparam int ST_CUR_CODE_LSB = 8;
   localparam int ST_RES_CODE_LSB = 12;
   localparam int POS_CURRENT_LSB = 16;

   // interrupt events
   localparam int IRQ_W = 3;
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_STANDSTILL_BIT = 1;
   localparam int IRQ_RESUME_BIT = 2;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

   // switch decode tables, indexed by code (switch off reads as one)
   localparam logic [10:0] CUR_MA_TABLE [0:7] = '{11'h0d2, 11'h0d2, 11'h1a4,
      11'h276, 11'h348, 11'h41a, 11'h4ec, 11'h5dc};
   localparam logic [15:0] RES_STEPS_TABLE [0:7] = '{16'h00c8, 16'h0190,
      16'h0320, 16'h0640, 16'h0c80, 16'h1900, 16'h3200, 16'h3200};
   localparam logic [7:0] STEP_INC_TABLE [0:7] = '{8'h40, 8'h20, 8'h10,
      8'h08, 8'h04, 8'h02, 8'h01, 8'h01};
   localparam logic [15:0] FINEST_STEPS = 16'h3200;
endpackage

// file: verilog/mdc_top.sv
// microstep drive control: switch decode, step tracking, standstill
// current reduction, fault latch, indicators and a small register port
// assumes all inputs synchronous to sys_clk; fault source from the power stage
`timescale 1ns/1ps
module mdc_top #(
   parameter int unsigned STANDSTILL_CYCLES_P = mdc_pkg::STANDSTILL_CYCLES
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic step_pulse_in,
   input wire logic step_dir_in,
   input wire logic drive_allow_in,
   input wire logic fault_detect_in,
   input wire logic current_sel_bit0,
   input wire logic current_sel_bit1,
   input wire logic current_sel_bit2,
   input wire logic resolution_sel_bit0,
   input wire logic resolution_sel_bit1,
   input wire logic resolution_sel_bit2,
   input wire logic [mdc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [mdc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [mdc_pkg::DATA_W-1:0] reg_rdata,
   output logic irq,
   output logic led_green,
   output logic led_red,
   output logic winding_enable,
   output logic [7:0] phase_pos,
   output logic [10:0] current_ma,
   output logic [15:0] microsteps_per_rev,
   output logic standstill
);
   import mdc_pkg::*;

   localparam int IDLE_W = $clog2(STANDSTILL_CYCLES_P + 1);
   localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(STANDSTILL_CYCLES_P - 1);

   logic [2:0] cur_code;
   logic [2:0] res_code;
   logic [10:0] full_ma;
   logic [10:0] reduced_ma;
   logic [17:0] reduce_prod;
   logic [7:0] step_inc;
   logic step_sync1_ff;
   logic step_sync2_ff;
   logic step_prev_ff;
   logic step_edge;
   logic [IDLE_W-1:0] idle_cnt_ff;
   logic standstill_ff;
   logic [7:0] phase_pos_ff;
   logic energised_ff;
   logic fault_ff;
   logic green_ff;
   logic [10:0] current_ma_ff;
   logic [1:0] ctrl_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   logic [IRQ_W-1:0] irq_event;
   logic [DATA_W-1:0] reg_rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic fault_set;

   // switch decode; an off switch reads high and counts as one
   assign cur_code = {current_sel_bit2, current_sel_bit1, current_sel_bit0};
   assign res_code = {resolution_sel_bit2, resolution_sel_bit1,
      resolution_sel_bit0};
   assign full_ma = CUR_MA_TABLE[cur_code];
   assign microsteps_per_rev = RES_STEPS_TABLE[res_code];
   // position counts in finest microsteps, so coarse settings jump further
   assign step_inc = STEP_INC_TABLE[res_code];

   // standstill level, truncated toward zero
   assign reduce_prod = 18'(full_ma) * 18'(REDUCE_PCT);
   assign reduced_ma = 11'(reduce_prod / 18'd100);

   // step input synchroniser; only the second stage feeds the edge detect
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         step_sync1_ff <= 1'b0;
         step_sync2_ff <= 1'b0;
         step_prev_ff <= 1'b0;
      end else if (clk_en) begin
         step_sync1_ff <= step_pulse_in;
         step_sync2_ff <= step_sync1_ff;
         step_prev_ff <= step_sync2_ff;
      end
   end
   assign step_edge = step_sync2_ff & ~step_prev_ff;

   // standstill timer, restarted by every qualified edge
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         idle_cnt_ff <= '0;
         standstill_ff <= 1'b0;
      end else if (clk_en) begin
         if (step_edge) begin
            idle_cnt_ff <= '0;
            standstill_ff <= 1'b0;
         end else if (idle_cnt_ff == IDLE_LAST) begin
            standstill_ff <= 1'b1;
         end else begin
            idle_cnt_ff <= idle_cnt_ff + 1'b1;
         end
      end
   end

   // commanded current; reduction can be switched off by software
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         current_ma_ff <= '0;
      end else if (clk_en) begin
         if (standstill_ff && ctrl_ff[CTRL_REDUCE_BIT]) begin
            current_ma_ff <= reduced_ma;
         end else begin
            current_ma_ff <= full_ma;
         end
      end
   end

   // phase position; steps while de-energised are dropped, the rotor is free
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_pos_ff <= '0;
      end else if (clk_en && step_edge && winding_enable) begin
         if (step_dir_in) begin
            phase_pos_ff <= phase_pos_ff + step_inc;
         end else begin
            phase_pos_ff <= phase_pos_ff - step_inc;
         end
      end
   end

   // enable follows the controller level one cycle later
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         energised_ff <= 1'b0;
      end else if (clk_en) begin
         energised_ff <= drive_allow_in;
      end
   end

   // fault latch; only reset leaves it, no register write clears it
   assign fault_set = fault_detect_in | ctrl_ff[CTRL_FORCE_FAULT_BIT];
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_ff <= 1'b0;
      end else if (clk_en && fault_set) begin
         fault_ff <= 1'b1;
      end
   end

   // power indicator comes on at the first enabled edge after reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         green_ff <= 1'b0;
      end else if (clk_en) begin
         green_ff <= 1'b1;
      end
   end

   assign led_green = green_ff;
   assign led_red = fault_ff;
   assign winding_enable = energised_ff & ~fault_ff;
   assign phase_pos = phase_pos_ff;
   assign current_ma = winding_enable ? current_ma_ff : 11'h000;
   assign standstill = standstill_ff;

   // interrupt events
   assign irq_event[IRQ_FAULT_BIT] = fault_set & ~fault_ff;
   assign irq_event[IRQ_STANDSTILL_BIT] = ~step_edge & ~standstill_ff &
      (idle_cnt_ff == IDLE_LAST);
   assign irq_event[IRQ_RESUME_BIT] = step_edge & standstill_ff;

   // sticky status, write one to clear; a new event beats the clear
   for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            irq_stat_ff[i] <= 1'b0;
         end else if (clk_en) begin
            if (irq_event[i]) begin
               irq_stat_ff[i] <= 1'b1;
            end else if (reg_wr && reg_addr == OFS_IRQ_STAT && reg_wdata[i]) begin
               irq_stat_ff[i] <= 1'b0;
            end
         end
      end
   end
   assign irq = |(irq_stat_ff & irq_mask_ff);

   // writable registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff <= CTRL_RESET;
         irq_mask_ff <= IRQ_MASK_RESET;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == OFS_CTRL) begin
            ctrl_ff <= reg_wdata[1:0];
         end
         if (reg_addr == OFS_IRQ_MASK) begin
            irq_mask_ff <= reg_wdata[IRQ_W-1:0];
         end
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      nxt_rdata = '0;
      case (reg_addr)
         OFS_CTRL: nxt_rdata[1:0] = ctrl_ff;
         OFS_STATUS: begin
            nxt_rdata[ST_FAULT_BIT] = fault_ff;
            nxt_rdata[ST_STANDSTILL_BIT] = standstill_ff;
            nxt_rdata[ST_ENERGISED_BIT] = winding_enable;
            nxt_rdata[ST_CUR_CODE_LSB +: 3] = cur_code;
            nxt_rdata[ST_RES_CODE_LSB +: 3] = res_code;
         end
         OFS_POSITION: begin
            nxt_rdata[7:0] = phase_pos_ff;
            nxt_rdata[POS_CURRENT_LSB +: 11] = current_ma;
         end
         OFS_IRQ_STAT: nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
         OFS_IRQ_MASK: nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
         default: nxt_rdata = '0;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_ff <= '0;
      end else if (clk_en) begin
         reg_rdata_ff <= reg_rd ? nxt_rdata : '0;
      end
   end
   assign reg_rdata = reg_rdata_ff;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   property p_res_decode;
      microsteps_per_rev * 16'(step_inc) == FINEST_STEPS;
   endproperty
   a_res_decode: assert property (p_res_decode)
      else $error("resolution and step size disagree");

   property p_cur_low;
      (cur_code == 3'h0 || cur_code == 3'h1) |-> full_ma == 11'h0d2;
   endproperty
   a_cur_low: assert property (p_cur_low)
      else $error("lowest current pattern decoded wrong");

   // compare against the level seen at the loading edge; switches may move after it
   property p_reduce;
      clk_en && standstill_ff && ctrl_ff[CTRL_REDUCE_BIT]
         |=> current_ma_ff == $past(reduced_ma);
   endproperty
   a_reduce: assert property (p_reduce)
      else $error("standstill current not reduced");

   property p_idle_restart;
      clk_en && step_edge |=> idle_cnt_ff == '0 && !standstill_ff;
   endproperty
   a_idle_restart: assert property (p_idle_restart)
      else $error("step edge did not restart the timer");

   property p_step_up;
      clk_en && step_edge && winding_enable && step_dir_in
         |=> phase_pos_ff == 8'($past(phase_pos_ff) + $past(step_inc));
   endproperty
   a_step_up: assert property (p_step_up)
      else $error("forward step not taken");

   property p_step_down;
      clk_en && step_edge && winding_enable && !step_dir_in
         |=> phase_pos_ff == 8'($past(phase_pos_ff) - $past(step_inc));
   endproperty
   a_step_down: assert property (p_step_down)
      else $error("reverse step not taken");

   property p_disable;
      clk_en && !drive_allow_in |=> !winding_enable;
   endproperty
   a_disable: assert property (p_disable)
      else $error("windings energised while disabled");

   // the release edge itself still resets the flop, so look one edge later
   property p_green;
      $past(clk_en) && $past(reset_n) |-> led_green;
   endproperty
   a_green: assert property (p_green)
      else $error("power indicator dark");

   property p_fault_free;
      clk_en && fault_detect_in |=> led_red && !winding_enable;
   endproperty
   a_fault_free: assert property (p_fault_free)
      else $error("fault did not free the shaft");

   property p_fault_hold;
      fault_ff |=> fault_ff [*8];
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault latch released");
endmodule
